// >>> core/ftd_decoder.sv
// flash thermometer decoder: latch control, capture and binary decode
`default_nettype none
module ftd_decoder
  import ftd_pkg::*;
(
  input wire logic clk, // 20 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic sampleStrobe, // one-cycle request to sample
  input wire logic [LINES-1:0] compLines, // comparator outputs, line 1 at bit 0
  output logic latchEn, // comparator latch enable, high = latched
  output logic latchEn_n, // complementary latch enable
  output ftd_result_t result, // registered decode result
  output logic [FULL_W-1:0] binWord, // code with overrange as bit 3
  output logic resultValid // one-cycle pulse with new result
);
  typedef enum logic [1:0] {IDLE, LATCH, CAPT} ftd_state_t;

  logic rstMeta_ff, rstSync_ff;
  logic [LINES-1:0] meta_ff, sync_ff;
  ftd_state_t state_ff, nxt_state;
  logic [LINES-1:0] therm_ff;
  ftd_result_t result_ff, nxt_result;
  logic valid_ff;
  logic [LINES:1] a;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // comparator lines are asynchronous, so two flops first
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      meta_ff <= THERM_ZERO;
      sync_ff <= THERM_ZERO;
    end else begin
      meta_ff <= compLines;
      sync_ff <= meta_ff;
    end
  end

  // sequence: strobe latches comparators, wait one cycle, capture
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      IDLE: begin
        if (sampleStrobe) begin
          nxt_state = LATCH;
        end
      end
      LATCH: nxt_state = CAPT; // frozen lines only reach meta_ff; capture takes lines sampled at the strobe edge
      CAPT: nxt_state = IDLE;
      default: nxt_state = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      state_ff <= IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // latched mode held from strobe until capture completes
  assign latchEn = (state_ff != IDLE); // RL9
  assign latchEn_n = ~latchEn; // RL9

  // whole word taken in one edge, never line by line
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      therm_ff <= THERM_ZERO;
    end else if (state_ff == CAPT) begin
      therm_ff <= sync_ff; // RL10
    end
  end

  assign a = sync_ff; // RL4 RL8
  // decode; bubbles in the thermometer give a defined but wrong code
  always_comb begin
    nxt_result.code[2] = a[4]; // RL1
    nxt_result.code[1] = a[6] | (a[2] & ~a[4]); // RL2
    nxt_result.code[0] = a[7] | (a[5] & ~a[6]) | (a[3] & ~a[4])
                         | (a[1] & ~a[2]); // RL3
    nxt_result.overrange = a[8]; // RL11
    if (a[8]) begin
      nxt_result.code = CODE_ZERO; // RL5
    end
  end

  // result and valid pulse on the capture edge
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      result_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= (state_ff == CAPT); // RL12
      if (state_ff == CAPT) begin
        result_ff <= nxt_result; // RL12
      end
    end
  end

  assign result = result_ff;
  // four-bit word: eight in-range codes plus the overrange state
  assign binWord = {result_ff.overrange, result_ff.code}; // RL5 RL6 RL7
  assign resultValid = valid_ff;
endmodule
`default_nettype wire

// >>> core/ftd_pkg.sv
// constants and types for the flash thermometer decoder
// Summary of operation
// [RL1] msb of the 3-bit result equals comparator line four directly
// [RL2] middle bit is line six, or line two with line four low
// [RL3] lsb ORs line seven and each odd line whose next line is low
// [RL4] input is seven equal thermometer lines plus one overrange line
// [RL5] all low gives zero, each line adds one, all high gives overrange
// [RL6] a 4-bit quantizer gives 16 states across 15 transition points
// [RL7] codes follow natural binary, lowest band all zeros
// [RL8] the 3-bit unit takes eight lines, the eighth for cascading
// [RL9] latch enables switch compare and latched modes; latched output frozen
// [RL10] all lines are sampled together in one comparison interval
// [RL11] two units make 4 bits, four units make 5, via overrange
// [RL12] result and overrange registered after the strobe with a valid pulse
`default_nettype none
package ftd_pkg;
  localparam int LINES = 8;
  localparam int CODE_W = 3;
  localparam int FULL_W = 4;
  localparam logic [LINES-1:0] THERM_ZERO = 8'h00;
  localparam logic [CODE_W-1:0] CODE_ZERO = 3'h0;
  localparam logic [FULL_W-1:0] OVR_CODE = 4'h8;
  localparam int CASCADE_W = 5;

  typedef struct packed {
    logic overrange;
    logic [CODE_W-1:0] code;
  } ftd_result_t;
endpackage
`default_nettype wire

// >>> tb/ftd_decoder_asserts.sv
// port checker for the decoder
`default_nettype none
module ftd_decoder_asserts import ftd_pkg::*; (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic sampleStrobe, // request
  input wire logic latchEn, // hold
  input wire logic latchEn_n, // hold inverse
  input wire ftd_result_t result, // result
  input wire logic [FULL_W-1:0] binWord, // word
  input wire logic resultValid // pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // latch window, pulse and word framing
  latch_pair_a: assert property (latchEn_n == !latchEn) else $error("pair");
  hold_two_a: assert property ($rose(latchEn) |=> latchEn ##1 !latchEn)
    else $error("hold");
  take_idle_a: assert property (sampleStrobe && !latchEn |=> latchEn)
    else $error("take");
  valid_end_a: assert property (resultValid == $fell(latchEn))
    else $error("valid");
  word_hold_a: assert property (!resultValid |-> $stable(binWord))
    else $error("word");
  ovr_zero_a: assert property (binWord[3] |-> binWord == OVR_CODE)
    else $error("ovr");
endmodule
bind ftd_decoder ftd_decoder_asserts chk(.clk(clk), .rst_n(rst_n),
  .sampleStrobe(sampleStrobe), .latchEn(latchEn), .latchEn_n(latchEn_n),
  .result(result), .binWord(binWord), .resultValid(resultValid));
`default_nettype wire

// >>> tb/ftd_comp_bank.sv
// comparator bank model with latch hold
`default_nettype none
module ftd_comp_bank import ftd_pkg::*; (
  input wire logic hold, // latched mode
  input wire logic holdN, // complement
  input wire logic [3:0] level, // input band
  output logic [LINES-1:0] compLines // lines
);
  logic [LINES-1:0] frz;
  wire logic [8:0] th = (9'h001 << level) - 9'h001;
  // freeze so a moving input cannot bubble the word
  always @(posedge hold) frz = th[7:0];
  assign compLines = (hold & ~holdN) ? frz : th[7:0];
endmodule
`default_nettype wire

// >>> tb/test_flash_thermometer_decoder.sv
// random and corner bench for the decoder
`default_nettype none
module test_flash_thermometer_decoder import ftd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, stb = 0, lEn, lEnN, resultValid;
  logic [3:0] level = 0, binWord;
  logic [7:0] lines;
  ftd_result_t result;
  logic [31:0] xs = 32'hb837;
  int errTotal = 0, checks = 0, n;
  ftd_decoder DUT(.clk(clk), .rst_n(rst_n), .sampleStrobe(stb),
    .compLines(lines), .latchEn(lEn), .latchEn_n(lEnN), .result(result),
    .binWord(binWord), .resultValid(resultValid));
  ftd_comp_bank bank(.hold(lEn), .holdN(lEnN), .level(level),
    .compLines(lines));
  function automatic logic [3:0] expCode(input logic [3:0] lv);
    return (lv == 4'h8) ? OVR_CODE : lv;
  endfunction
  task automatic cmp(input string w, input logic [3:0] e, s);
    checks++;
    if (s !== e) begin
      errTotal++;
      $display("unexpected %s exp %h got %h", w, e, s);
    end
  endtask
  task automatic wrapUp;
    $display("errors %0d checks %0d", errTotal, checks);
    if (errTotal == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  // watchdog: 30 samples of about 7 cycles each
  initial begin
    #20000;
    errTotal++;
    wrapUp;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    cmp("reset", 4'h0, binWord);
    for (int i = 0; i < 30; i++) begin
      xs = xs ^ (xs << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
      level <= (i < 9) ? i[3:0] : 4'(xs % 9);
      repeat (3) @(posedge clk);
      stb <= 1;
      @(posedge clk);
      stb <= 0;
      n = 0;
      while (resultValid !== 1'b1 && n < 8) begin
        @(posedge clk);
        n++;
      end
      cmp("resultValid", 4'h1, {3'h0, resultValid});
      cmp("binWord", expCode(level), binWord);
      cmp("result", expCode(level), result);
    end
    wrapUp;
  end
endmodule
`default_nettype wire
